/* File: hdl/gpc_port_ctrl.sv */
// Port A..D pad control: direction, data latches, pull-ups with a global
// strength select, Port A wake-up, source-current levels, APB registers.
// Assumes pins are asynchronous to pclk; alt_sel, alt_od and low_power
// come from logic on pclk.
`timescale 1ns/10ps

// Function
// - Each implemented pin has a pull-up enable bit, 1 connects and 0 disconnects, cleared at reset.
// - A pull-up is applied only while the pin is a digital input or an open-drain output.
// - One global strength bit picks weak (0) or strong (1) pull-ups and resets to 0.
// - The strength bit never turns on a pull-up whose enable is off.
// - In sleep or idle, a high-to-low change on a wake-enabled Port A pin raises a wake-up request.
// - Wake-up enable counts only for a general purpose input while in idle or sleep.
// - Port A has an eight-bit wake-up enable register, bit n for pin n, cleared at reset.
// - Each pin has a direction bit, 1 input and 0 push-pull output, set to 1 at reset.
// - A data read of an input pin returns the level on the pin.
// - A data read of an output pin with input read disabled returns the output latch.
// - Output latches hold until the data register is written again; inputs are sampled at the read.
// - A group's source-current level acts only on pins driven as push-pull outputs.
// - Drive register 0 holds PB7-4, PB3-0, PA7-4, PA3-0 in bit pairs 7-6 down to 1-0, reset 0.
// - In the small variant drive register 1 holds PD3-0, PC5-4, PC3-0 in bits 5-0, bits 7-6 read 0.
// - In the large variant drive register 1 adds PD5-4 at bits 7-6, and bits 3-2 cover PC7-4.
// - Unimplemented bits read as 0 and ignore writes.
module gpc_port_ctrl
	import gpc_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b0
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [GPC_ADDR_W-1:0] paddr, // APB byte address
	input wire logic [GPC_DATA_W-1:0] pwdata, // APB write data
	output logic [GPC_DATA_W-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire gpc_pins_t pin_in, // Pad input levels, async
	input wire gpc_pins_t alt_sel, // 1: pin given to a shared function
	input wire gpc_pins_t alt_od, // 1: shared function is open-drain
	input wire logic low_power, // Idle or sleep mode
	output gpc_pins_t pad_out, // Pad output value
	output gpc_pins_t pad_oe, // Pad output enable
	output gpc_pins_t pad_pu, // Pull-up connected
	output gpc_pins_t pad_pu_strong, // Strong pull-up selected
	output gpc_drv_t pad_drv, // Source-current level per pin
	output logic wake_req, // Wake-up pulse
	output logic irq // Level interrupt
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [3:0][7:0] data_ff, dir_ff, pull_ff, impl;
	logic [7:0] wake_en_ff, drv0_ff, drv1_ff, drv1_mask;
	logic strong_ff, read_in_ff;
	logic [7:0] irq_stat_ff, irq_en_ff;
	logic [31:0] sync1_ff, sync2_ff, prev_ff;
	logic [31:0] pin_gpio, pin_is_in, pu_on, pp_out;
	logic [7:0] wake_hit;
	logic setup_ph, wr_commit, port_hit, map_hit;
	logic [1:0] acc_port, acc_kind;
	logic [7:0] wr_byte, rd_byte, rd_pins, clr_bits;
	logic [GPC_DATA_W-1:0] prdata_ff;
	logic pready_ff, pslverr_ff, wake_req_ff, irq_ff;
	gpc_pins_t pad_out_ff, pad_oe_ff, pad_pu_ff, pad_strong_ff;
	gpc_drv_t drv_ff, drv_c;

	// Implemented pins per port and variant
	assign impl[0] = GPC_MASK_FULL;
	assign impl[1] = GPC_MASK_FULL;
	assign impl[2] = LARGE_VARIANT ? GPC_MASK_FULL : GPC_MASK_C_SMALL;
	assign impl[3] = LARGE_VARIANT ? GPC_MASK_D_LARGE : GPC_MASK_D_SMALL;
	assign drv1_mask = LARGE_VARIANT ? GPC_MASK_FULL : GPC_MASK_DRV1_SMALL;

	// ****************************************************************
	// APB decode
	// ****************************************************************
	// Zero-wait slave: read data is captured in setup, writes commit in access, ready raised for access
	assign setup_ph = psel & ~penable;
	assign wr_commit = psel & penable & pready_ff & pwrite;
	assign acc_port = paddr[5:4];
	assign acc_kind = paddr[3:2];
	assign port_hit = (paddr <= GPC_OFS_PORT_LAST) && (paddr[1:0] == 2'h0) &&
		((acc_kind != GPC_KIND_WAKE) || (acc_port == 2'(GPC_PORT_A)));
	assign map_hit = port_hit || (paddr == GPC_OFS_STRENGTH) || (paddr == GPC_OFS_DRIVE0) ||
		(paddr == GPC_OFS_DRIVE1) || (paddr == GPC_OFS_CTRL) || (paddr == GPC_OFS_IRQ_STAT) ||
		(paddr == GPC_OFS_IRQ_CLR) || (paddr == GPC_OFS_IRQ_EN);
	assign wr_byte = pwdata[7:0];

	// Pin level or latch per bit, sampled at the read
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			if (dir_ff[acc_port][b] || read_in_ff) begin
				rd_pins[b] = sync2_ff[{acc_port, 3'(b)}];
			end else begin
				rd_pins[b] = data_ff[acc_port][b];
			end
		end
	end

	// Read multiplexer; unimplemented bits come back zero
	always_comb begin
		rd_byte = GPC_RST_ZERO;
		if (port_hit) begin
			case (acc_kind)
				GPC_KIND_DATA: rd_byte = rd_pins & impl[acc_port];
				GPC_KIND_DIR: rd_byte = dir_ff[acc_port] & impl[acc_port];
				GPC_KIND_PULL: rd_byte = pull_ff[acc_port] & impl[acc_port];
				default: rd_byte = wake_en_ff;
			endcase
		end else begin
			case (paddr)
				GPC_OFS_STRENGTH: rd_byte = {7'h00, strong_ff};
				GPC_OFS_DRIVE0: rd_byte = drv0_ff;
				GPC_OFS_DRIVE1: rd_byte = drv1_ff & drv1_mask;
				GPC_OFS_CTRL: rd_byte = {7'h00, read_in_ff};
				GPC_OFS_IRQ_STAT: rd_byte = irq_stat_ff;
				GPC_OFS_IRQ_EN: rd_byte = irq_en_ff;
				default: rd_byte = GPC_RST_ZERO;
			endcase
		end
	end

	// Bus answer registered in setup so every bus output is a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= setup_ph;
			if (setup_ph) begin
				prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
				pslverr_ff <= ~map_hit;
			end
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	// Per-port data, direction and pull-up; writes masked to real pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_ff <= {4{GPC_RST_ZERO}};
			dir_ff <= {4{GPC_RST_DIR}};
			pull_ff <= {4{GPC_RST_ZERO}};
		end else if (wr_commit && port_hit) begin
			case (acc_kind)
				GPC_KIND_DATA: data_ff[acc_port] <= wr_byte & impl[acc_port];
				GPC_KIND_DIR: dir_ff[acc_port] <= (wr_byte & impl[acc_port]) | ~impl[acc_port];
				GPC_KIND_PULL: pull_ff[acc_port] <= wr_byte & impl[acc_port];
				default: ;
			endcase
		end
	end

	// Port A wake enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_en_ff <= GPC_RST_ZERO;
		end else if (wr_commit && port_hit && acc_kind == GPC_KIND_WAKE) begin
			wake_en_ff <= wr_byte;
		end
	end

	// Global byte registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strong_ff <= 1'b0;
			drv0_ff <= GPC_RST_ZERO;
			drv1_ff <= GPC_RST_ZERO;
			read_in_ff <= 1'b0;
			irq_en_ff <= GPC_RST_ZERO;
		end else if (wr_commit) begin
			case (paddr)
				GPC_OFS_STRENGTH: strong_ff <= wr_byte[GPC_BIT_STRONG];
				GPC_OFS_DRIVE0: drv0_ff <= wr_byte;
				GPC_OFS_DRIVE1: drv1_ff <= wr_byte & drv1_mask;
				GPC_OFS_CTRL: read_in_ff <= wr_byte[GPC_BIT_INPUT_READ];
				GPC_OFS_IRQ_EN: irq_en_ff <= wr_byte;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Pin sampling and wake-up
	// ****************************************************************
	// Two-stage synchroniser; prev_ff follows the second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 32'h0000_0000;
			sync2_ff <= 32'h0000_0000;
			prev_ff <= 32'h0000_0000;
		end else begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	// Pin roles used by the gating below
	assign pin_gpio = ~alt_sel;
	assign pin_is_in = dir_ff;
	assign pp_out = pin_gpio & ~pin_is_in;

	// Falling edge on an enabled general purpose input while halted
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			wake_hit[b] = low_power && wake_en_ff[b] && pin_gpio[b] && pin_is_in[b] &&
				prev_ff[b] && !sync2_ff[b];
		end
	end

	// Status is sticky; a new edge beats a clear in the same cycle
	assign clr_bits = (wr_commit && paddr == GPC_OFS_IRQ_CLR) ? wr_byte : GPC_RST_ZERO;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= GPC_RST_ZERO;
			wake_req_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~clr_bits) | wake_hit;
			wake_req_ff <= |wake_hit;
			irq_ff <= |(irq_stat_ff & irq_en_ff);
		end
	end

	// ****************************************************************
	// Pad controls
	// ****************************************************************
	// Pull-up only on digital inputs or open-drain shared outputs
	assign pu_on = pull_ff & ((pin_gpio & pin_is_in) | (alt_sel & alt_od));

	// Level per pin from its group; low half and high half of each port
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_drv
			localparam int PORT = gi / 8;
			localparam int HI = ((gi % 8) >= GPC_HALF) ? 1 : 0;
			localparam int LO_BIT = ((PORT % 2) * 4) + (HI * 2);
			logic [1:0] grp;
			assign grp = (PORT < GPC_PORT_C) ? drv0_ff[LO_BIT +: 2] : drv1_ff[LO_BIT +: 2];
			assign drv_c[gi] = pp_out[gi] ? grp : 2'h0;
		end
	endgenerate

	// Pad outputs follow the registers one cycle after a write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out_ff <= '0;
			pad_oe_ff <= '0;
			pad_pu_ff <= '0;
			pad_strong_ff <= '0;
			drv_ff <= '0;
		end else begin
			pad_out_ff <= data_ff & pp_out;
			pad_oe_ff <= pp_out;
			pad_pu_ff <= pu_on;
			pad_strong_ff <= pu_on & {32{strong_ff}};
			drv_ff <= drv_c;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign pad_out = pad_out_ff;
	assign pad_oe = pad_oe_ff;
	assign pad_pu = pad_pu_ff;
	assign pad_pu_strong = pad_strong_ff;
	assign pad_drv = drv_ff;
	assign wake_req = wake_req_ff;
	assign irq = irq_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [31:0] drv_any;
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			drv_any[i] = |pad_drv[i];
		end
	end

	AST_PU_NEEDS_ENABLE: assert property ((pad_pu & ~$past(pull_ff)) == 32'h0)
		else $error("pull-up on without its enable");
	AST_PU_ROLE: assert property (!$past(alt_sel[0]) && $past(dir_ff[0][0]) == 1'b0 |-> !pad_pu[0])
		else $error("pull-up on a push-pull output");
	AST_STRONG_SELECT: assert property (pad_pu_strong == (pad_pu & {32{$past(strong_ff)}}))
		else $error("strength select does not follow the strength bit");
	AST_STRONG_ONLY_ENABLED: assert property ((pad_pu_strong & ~pad_pu) == 32'h0)
		else $error("strong pull-up on a disabled pull-up");
	AST_WAKE_ON_FALL: assert property (low_power && wake_en_ff[0] && dir_ff[0][0] && !alt_sel[0] &&
		prev_ff[0] && !sync2_ff[0] |=> wake_req && irq_stat_ff[0])
		else $error("falling edge missed for wake-up");
	AST_WAKE_NEEDS_HALT: assert property (wake_req |-> $past(low_power))
		else $error("wake-up while not halted");
	AST_DIR_OUTPUT: assert property (pad_oe[0] |-> $past(dir_ff[0][0]) == 1'b0)
		else $error("pad driven while configured as input");
	AST_READ_PIN: assert property (setup_ph && !pwrite && paddr == GPC_OFS_PA_DATA && dir_ff[0] == GPC_RST_DIR
		|=> prdata[7:0] == $past(sync2_ff[7:0]))
		else $error("input read does not return the pin level");
	AST_READ_LATCH: assert property (setup_ph && !pwrite && paddr == GPC_OFS_PA_DATA && dir_ff[0] == 8'h00 &&
		!read_in_ff |=> prdata[7:0] == $past(data_ff[0]))
		else $error("output read does not return the latch");
	AST_LATCH_HOLD: assert property (!(wr_commit && port_hit && acc_kind == GPC_KIND_DATA) |=> $stable(data_ff))
		else $error("output latch changed without a write");
	AST_DRV_GATED: assert property ((drv_any & ~pad_oe) == 32'h0)
		else $error("drive level on a pin that is not driven");
	AST_UNIMPL_ZERO: assert property (setup_ph && !pwrite && paddr == GPC_OFS_STRENGTH
		|=> prdata[31:1] == 31'h0000_0000)
		else $error("unimplemented strength bits read non-zero");
	AST_WRITE_TO_PAD: assert property (wr_commit && paddr == GPC_OFS_DRIVE0 && dir_ff[0][0] == 1'b0 && !alt_sel[0]
		##1 (dir_ff[0][0] == 1'b0 && !alt_sel[0]) |=> pad_drv[0] == $past(drv0_ff[1:0], 1))
		else $error("written drive level not on the pin next cycle");

	COV_WAKE: cover property (low_power ##1 wake_req ##1 irq_stat_ff[0]);
	COV_IRQ_CLEAR: cover property (irq ##[1:4] (wr_commit && paddr == GPC_OFS_IRQ_CLR) ##2 !irq);
	COV_READ_PIN: cover property (setup_ph && !pwrite && paddr == GPC_OFS_PA_DATA ##1 pready);
	COV_STRONG: cover property (pad_pu_strong != 32'h0);

endmodule // gpc_port_ctrl

/* File: hdl/gpc_pkg.sv */
// Package for the port pad control block: register map, reset values,
// field positions and the packed carriers for pin groups.
// Assumes a 32-bit APB slave with byte-wide registers in the low lane.
package gpc_pkg;

	// ****************************************************************
	// Bus and map
	// ****************************************************************
	localparam int GPC_ADDR_W = 8;
	localparam int GPC_DATA_W = 32;
	// Per-port block: paddr[5:4] picks port, paddr[3:2] picks the kind
	localparam logic [1:0] GPC_KIND_DATA = 2'h0;
	localparam logic [1:0] GPC_KIND_DIR = 2'h1;
	localparam logic [1:0] GPC_KIND_PULL = 2'h2;
	localparam logic [1:0] GPC_KIND_WAKE = 2'h3;
	localparam logic [GPC_ADDR_W-1:0] GPC_OFS_PORT_LAST = 8'h3C;
	localparam logic [GPC_ADDR_W-1:0] GPC_OFS_PA_DATA = 8'h00;
	localparam logic [GPC_ADDR_W-1:0] GPC_OFS_STRENGTH = 8'h40;
	localparam logic [GPC_ADDR_W-1:0] GPC_OFS_DRIVE0 = 8'h44;
	localparam logic [GPC_ADDR_W-1:0] GPC_OFS_DRIVE1 = 8'h48;
	localparam logic [GPC_ADDR_W-1:0] GPC_OFS_CTRL = 8'h4C;
	localparam logic [GPC_ADDR_W-1:0] GPC_OFS_IRQ_STAT = 8'h50;
	localparam logic [GPC_ADDR_W-1:0] GPC_OFS_IRQ_CLR = 8'h54;
	localparam logic [GPC_ADDR_W-1:0] GPC_OFS_IRQ_EN = 8'h58;

	// ****************************************************************
	// Reset values and field positions
	// ****************************************************************
	localparam logic [7:0] GPC_RST_ZERO = 8'h00;
	localparam logic [7:0] GPC_RST_DIR = 8'hFF;
	localparam int GPC_BIT_STRONG = 0;
	localparam int GPC_BIT_INPUT_READ = 0;
	// Implemented pins per port, small and large variant
	localparam logic [7:0] GPC_MASK_FULL = 8'hFF;
	localparam logic [7:0] GPC_MASK_C_SMALL = 8'h3F;
	localparam logic [7:0] GPC_MASK_D_SMALL = 8'h0F;
	localparam logic [7:0] GPC_MASK_D_LARGE = 8'h3F;
	localparam logic [7:0] GPC_MASK_DRV1_SMALL = 8'h3F;
	localparam logic [7:0] GPC_MASK_STRENGTH = 8'h01;
	localparam logic [7:0] GPC_MASK_CTRL = 8'h01;
	localparam int GPC_PORT_A = 0;
	localparam int GPC_PORT_C = 2;
	localparam int GPC_HALF = 4;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [7:0] pd;
		logic [7:0] pc;
		logic [7:0] pb;
		logic [7:0] pa;
	} gpc_pins_t;

	typedef logic [31:0][1:0] gpc_drv_t;

endpackage

/* File: verification/gpc_pin_load.sv */
// Model of what hangs on the port pins: switches and shorts, pads, pull-ups.
// Assumes pad outputs come from the pad control block on pclk.
`timescale 1ns/10ps

module gpc_pin_load
	import gpc_pkg::*;
(
	input wire logic pclk, // System clock
	input wire gpc_pins_t pad_out, // Pad output value
	input wire gpc_pins_t pad_oe, // Pad output enable
	input wire gpc_pins_t pad_pu, // Pull-up connected
	input wire gpc_pins_t sw_en, // 1: switch or short holds the pin
	input wire gpc_pins_t sw_lvl, // Level forced by the switch
	output gpc_pins_t pin_in // Resulting pin level
);
	gpc_pins_t last_ff = '0;

	// Last level, so a floating pin never sits still
	always_ff @(posedge pclk) begin
		last_ff <= pin_in;
	end

	// A hard short beats the pad; a floating pin toggles every cycle
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (sw_en[i])
				pin_in[i] = sw_lvl[i];
			else if (pad_oe[i])
				pin_in[i] = pad_out[i];
			else if (pad_pu[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = ~last_ff[i];
		end
	end
endmodule // gpc_pin_load

/* File: verification/gpio_port_pad_control_test.sv */
// Self-checking bench of the pad control block, small variant.
// Assumes an APB slave that raises pready; pins come from the load model.
`timescale 1ns/10ps

module gpio_port_pad_control_test;
	import gpc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, low_power, wake_req, irq, e;
	logic [GPC_ADDR_W-1:0] paddr;
	logic [GPC_DATA_W-1:0] pwdata, prdata, r;
	gpc_pins_t pin_in, alt_sel, alt_od, pad_out, pad_oe, pad_pu, pad_pu_strong, sw_en, sw_lvl;
	gpc_drv_t pad_drv;
	int n_fail, check_count, cyc, wake_n;

	gpc_port_ctrl #(.LARGE_VARIANT(1'b0)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .alt_sel(alt_sel), .alt_od(alt_od), .low_power(low_power), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pu_strong(pad_pu_strong), .pad_drv(pad_drv),
		.wake_req(wake_req), .irq(irq));
	gpc_pin_load load (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .sw_en(sw_en),
		.sw_lvl(sw_lvl), .pin_in(pin_in));

	// ********************************
	// Clock, watchdog, wake pulse count
	// ********************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (wake_req === 1'b1) wake_n++;
		if (cyc == 6000) begin
			n_fail++;
			summarize();
		end
	end

	// ********************************
	// Bus and compare helpers
	// ********************************
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, ex, got);
		end
	endtask
	// Request held until pready is seen high at a rising edge; the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] ex);
		apb(1'b0, a, 8'h00);
		chk(nm, {24'h0, ex}, r);
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge pclk);
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_reset();
		logic [7:0] dir_ex [4] = '{8'hFF, 8'hFF, 8'h3F, 8'h0F};
		for (int p = 0; p < 4; p++) begin
			rd("dir", 8'(p * 16 + 4), dir_ex[p]);
			rd("pull", 8'(p * 16 + 8), 8'h00);
		end
		rd("wake en", 8'h0C, 8'h00);
		rd("strength", GPC_OFS_STRENGTH, 8'h00);
		rd("drive0", GPC_OFS_DRIVE0, 8'h00);
		chk("oe", 32'h0, pad_oe);
		chk("pu rst", 32'h0, pad_pu);
		$display("t_reset done");
	endtask
	task automatic t_regs();
		wr(GPC_OFS_STRENGTH, 8'hFF);
		rd("strength", GPC_OFS_STRENGTH, 8'h01);
		wr(GPC_OFS_STRENGTH, 8'h00);
		wr(GPC_OFS_DRIVE1, 8'hFF);
		rd("drive1", GPC_OFS_DRIVE1, 8'h3F);
		wr(GPC_OFS_DRIVE0, 8'hFF);
		rd("drive0", GPC_OFS_DRIVE0, 8'hFF);
		apb(1'b0, 8'h1C, 8'h00);
		chk("unmapped err", 32'h1, {31'h0, e});
		wr(GPC_OFS_IRQ_STAT, 8'hFF);
		rd("status ro", GPC_OFS_IRQ_STAT, 8'h00);
		$display("t_regs done");
	endtask
	task automatic t_output();
		wr(GPC_OFS_DRIVE0, 8'h1B);
		wr(GPC_OFS_PA_DATA, 8'hA5);
		wr(8'h04, 8'h00);
		tick(1);
		chk("oe before", 32'h0, pad_oe);
		tick(1);
		chk("oe after", 32'h0000_00FF, pad_oe);
		chk("out", 32'h0000_00A5, pad_out);
		chk("drv pa0", 32'h3, {30'h0, pad_drv[0]});
		chk("drv pa4", 32'h2, {30'h0, pad_drv[4]});
		chk("drv pb0", 32'h0, {30'h0, pad_drv[8]});
		@(posedge pclk);
		sw_en.pa <= 8'h01;
		rd("latch", GPC_OFS_PA_DATA, 8'hA5);
		wr(GPC_OFS_CTRL, 8'h01);
		rd("pin", GPC_OFS_PA_DATA, 8'hA4);
		wr(GPC_OFS_CTRL, 8'h00);
		wr(8'h04, 8'hFF);
		$display("t_output done");
	endtask
	task automatic t_pull();
		wr(8'h18, 8'hFF);
		wr(8'h14, 8'h0F);
		tick(2);
		chk("pu", 32'h0000_0F00, pad_pu);
		chk("strong off", 32'h0, pad_pu_strong);
		wr(GPC_OFS_STRENGTH, 8'h01);
		tick(2);
		chk("strong", 32'h0000_0F00, pad_pu_strong);
		@(posedge pclk);
		alt_sel.pb <= 8'h03;
		alt_od.pb <= 8'h01;
		tick(3);
		chk("pu alt", 32'h0000_0D00, pad_pu);
		@(posedge pclk);
		alt_sel.pb <= 8'h00;
		$display("t_pull done");
	endtask
	task automatic t_input();
		@(posedge pclk);
		sw_en.pc <= 8'h3F;
		sw_lvl.pc <= 8'h15;
		tick(3);
		rd("pc in", 8'h20, 8'h15);
		$display("t_input done");
	endtask
	task automatic t_wake();
		@(posedge pclk);
		sw_en.pa <= 8'hFF;
		sw_lvl.pa <= 8'hFF;
		wr(8'h0C, 8'h01);
		wr(GPC_OFS_IRQ_EN, 8'h01);
		rd("pa in", GPC_OFS_PA_DATA, 8'hFF);
		@(posedge pclk);
		sw_lvl.pa <= 8'hFE;
		tick(6);
		chk("wake awake", 32'h0, 32'(wake_n));
		@(posedge pclk);
		sw_lvl.pa <= 8'hFF;
		low_power <= 1'b1;
		tick(4);
		@(posedge pclk);
		sw_lvl.pa <= 8'hFD;
		tick(6);
		chk("wake off pin", 32'h0, 32'(wake_n));
		@(posedge pclk);
		sw_lvl.pa <= 8'hFC;
		tick(6);
		chk("wake", 32'h1, 32'(wake_n));
		chk("irq", 32'h1, {31'h0, irq});
		rd("status", GPC_OFS_IRQ_STAT, 8'h01);
		wr(GPC_OFS_IRQ_EN, 8'h00);
		tick(2);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(GPC_OFS_IRQ_EN, 8'h01);
		tick(2);
		chk("irq again", 32'h1, {31'h0, irq});
		wr(GPC_OFS_IRQ_CLR, 8'h01);
		tick(2);
		chk("irq clr", 32'h0, {31'h0, irq});
		rd("status clr", GPC_OFS_IRQ_STAT, 8'h00);
		$display("t_wake done");
	endtask

	// One exit for pass, fail and timeout
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, low_power} = 5'h00;
		{paddr, pwdata} = '0;
		{alt_sel, alt_od, sw_en, sw_lvl} = '0;
		n_fail = 0;
		check_count = 0;
		cyc = 0;
		wake_n = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_output();
		t_pull();
		t_input();
		t_wake();
		summarize();
	end
endmodule // gpio_port_pad_control_test
